// ===== bench/ucel_core_checker.sv
// Purpose: port assertions for ucel_core
// Assumes: apb timing of the core
// Notes:   bound to every ucel_core instance
`timescale 1ns/1ps
`default_nettype none
module ucel_core_checker #(parameter int BAUD_DIV = 16) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        xck,
    input wire logic        txd,
    input wire logic        standby,
    input wire logic        gclk_request,
    input wire logic        wake_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire acc    = psel && penable;
    wire mapped = paddr inside {8'h00, 8'h04, 8'h14, 8'h18, 8'h1c, 8'h28};
    sequence s_srst; acc && pwrite && pready && paddr == 8'h00 && pwdata[0]; endsequence
    sequence s_wr; acc && pwrite; endsequence
    a_srst_write_err: assert property (s_srst ##[1:3] s_wr |-> pslverr) else $error("write in reset accepted");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("unmapped access accepted");
    a_err_phase: assert property (pslverr |-> acc) else $error("error outside access phase");
    a_ready_data: assert property (!pready |-> acc && pwrite && paddr == 8'h28) else $error("bad stall");
    a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    a_txd_idle: assert property ($rose(rst_b) |-> txd [*8]) else $error("line not idle after reset");
    a_wake_pulse: assert property (wake_request |=> !wake_request) else $error("wake longer than a cycle");
    a_gclk_awake: assert property (!standby |-> gclk_request) else $error("clock dropped while awake");
endmodule : ucel_core_checker
bind ucel_core ucel_core_checker #(.BAUD_DIV(BAUD_DIV)) u_chk (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .xck, .txd, .standby, .gclk_request, .wake_request);
`default_nettype wire

// ===== bench/ucel_core_tb.sv
// Purpose: self-checking bench for ucel_core
// Assumes: internal clock mode, parity frames, small baud divider
// Notes:   drivers queue notes, watchers compare
`timescale 1ns/1ps
`default_nettype none
module ucel_core_tb;
    localparam int DIV = 4;
    logic clock, rst_b, psel, penable, pwrite, standby, rxd, xck, txd, gclk_request, wake_request, pready, pslverr, got;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, cb;
    logic [9:0]  word, q_line[$];
    logic [32:0] seen, q_reg[$];
    logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c};
    int          err_total = 0, total_checks = 0, wakes = 0;
    event        look_ev;
    ucel_core #(.BAUD_DIV(DIV)) u_ucel_core (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxd, .xck, .txd, .standby, .gclk_request, .wake_request);
    ucel_line_model #(.BIT(DIV * 5)) u_ucel_line_model (.txd, .rxd, .xck, .word, .got);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic bound(input logic hit);
        if (hit) begin
            err_total++;
            end_sim();
        end
    endtask : bound
    task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    always @(look_ev) check("register", seen, q_reg.pop_front());
    always @(posedge got) check("line", {23'h0, word}, {23'h0, q_line.pop_front()});
    always @(posedge wake_request) wakes++;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, input logic [32:0] e);
        int n;
        n = 0;
        @(negedge clock);
        {psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b0, w, a, d};
        @(negedge clock);
        penable = 1'b1;
        #1;
        while (pready !== 1'b1 && n < 300) begin
            @(negedge clock);
            #1 n++;
        end
        bound(n >= 300);
        seen = {pslverr, w ? 32'h0 : prdata};
        if (c) begin
            q_reg.push_back(e);
            ->look_ev;
        end
        @(negedge clock);
        {psel, penable} = 2'b00;
    endtask : apb
    task automatic poll;
        int n;
        n = 0;
        do begin
            apb('0, 8'h1c, '0, '0, '0);
            n++;
        end while (seen[31:0] !== 32'h0 && n < 50);
        bound(n >= 50);
    endtask : poll
    initial begin
        int n;
        {rst_b, psel, penable, pwrite, paddr, pwdata, standby} = '0;
        seed = 32'h3f09;
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        apb('1, 8'h08, '0, '1, {1'b1, 32'h0});
        foreach (ra[i]) apb('0, ra[i], '0, '1, '0);
        for (int p = 0; p < 2; p++) begin
            cb = 32'h0003_0200 | (32'(p) << 13);
            apb('1, 8'h00, 32'h0100_0007, '1, '0);
            if (p == 0) apb('0, 8'h00, '0, '1, 33'h1);
            else apb('1, 8'h04, cb, '1, {1'b1, 32'h0});
            poll();
            apb('0, 8'h04, '0, '1, '0);
            apb('0, 8'h00, '0, '1, '0);
            apb('1, 8'h00, 32'h0100_0004, '0, '0);
            apb('1, 8'h04, cb, '0, '0);
            apb('1, 8'h14, 32'h8, '0, '0);
            apb('0, 8'h04, '0, '1, {1'b0, cb});
            apb('1, 8'h00, 32'h0100_0006, '0, '0);
            apb('0, 8'h1c, '0, '1, 33'h2);
            apb('0, 8'h00, '0, '1, 33'h0100_0006);
            poll();
            repeat (4) begin
                seed = xs(seed);
                q_line.push_back({1'b1, ^seed[7:0] ^ p[0], seed[7:0]});
                apb('1, 8'h28, {24'h0, seed[7:0]}, '0, '0);
            end
            apb('1, 8'h04, cb & ~32'h0001_0000, '0, '0);
            n = 0;
            while (q_line.size() > 0 && n < 5000) begin
                @(negedge clock);
                n++;
            end
            bound(n >= 5000);
            standby = 1'b1;
            u_ucel_line_model.send(seed[15:8], ^seed[15:8] ^ p[0]);
            apb('0, 8'h28, '0, '1, {25'h0, seed[15:8]});
            apb('0, 8'h18, '0, '1, '0);
            u_ucel_line_model.send(seed[15:8], ~(^seed[15:8] ^ p[0]));
            apb('0, 8'h18, '0, '1, 33'h1);
            standby = 1'b0;
            apb('1, 8'h04, '0, '0, '0);
            apb('0, 8'h18, '0, '1, '0);
            $display("pass %0d done", p);
        end
        standby = 1'b1;
        repeat (4) @(negedge clock);
        seen = {wakes, gclk_request};
        q_reg.push_back({32'h4, 1'b0});
        ->look_ev;
        standby = 1'b0;
        $display("standby test done");
        @(negedge clock);
        end_sim();
    end
endmodule : ucel_core_tb
`default_nettype wire

// ===== bench/ucel_line_model.sv
// Purpose: remote serial device on the line side
// Assumes: 8 data bits, parity bit, one stop bit
// Notes:   xck toggles only inside frames it sends
`timescale 1ns/1ps
`default_nettype none
module ucel_line_model #(parameter int BIT = 20) (
    input  wire logic       txd,
    output var  logic       rxd,
    output var  logic       xck,
    output var  logic [9:0] word,
    output var  logic       got
);
    initial begin
        {rxd, xck, got, word} = {1'b1, 12'h0};
    end
    // mid-bit sampling of frames from the block
    always begin
        @(negedge txd);
        #(BIT / 2);
        for (int i = 0; i < 10; i++) begin
            #(BIT);
            word[i] = txd;
        end
        got = 1'b1;
        #1 got = 1'b0;
    end
    task automatic send(input logic [7:0] d, input logic par);
        logic [10:0] f;
        f = {1'b1, par, d, 1'b0};
        fork
            for (int i = 0; i < 11; i++) begin
                rxd = f[i];
                #(BIT);
            end
            repeat (4) #62.5 xck = ~xck;
        join
        #(BIT * 4);
    endtask : send
endmodule : ucel_line_model
`default_nettype wire

// ===== hw/ucel_buf_if.sv
// Purpose: valid/ready word carrier between the core and its buffer
// Assumes: one clock
// Notes:   fill side pushes, drain side pops
`timescale 1ns/1ps
`default_nettype none
interface ucel_buf_if #(parameter int W = 9);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : ucel_buf_if
`default_nettype wire

// ===== hw/ucel_core.sv
// Purpose: control, enable and frame engine of a serial port
// Assumes: APB slave, pins and clock pin from outside the clock domain
// Notes:   transmit words pass a two-entry buffer; full stalls pready
`timescale 1ns/1ps
`default_nettype none
`include "ucel_params.svh"

// What this block does
// - external clock, no standby run: drop reception
// - internal clock, no standby run: stop clock
// - standby run: keep clock, wider wake sources
// - mode field selects external or internal clock
// - enable reads back, busy until done
// - soft reset clears registers, disables port
// - soft reset beats other written fields
// - during reset: write errors, reads reset
// - reset bit and busy clear together
// - receiver off flushes buffer, clears errors except collision
// - receiver on while disabled: immediate
// - receiver on while enabled: busy until running
// - transmitter off only after drain
// - transmitter on: immediate or busy handshake
// - transmitter appends even or odd parity
// - receiver checks parity, flags mismatch
// - encoding bit selects plain or pulse line
// - start-bit wake off when bit clear
// - start wake via enabled start/complete events
// - collision check when enable bit set, plain line only
// - one or two stop bits
// - character width 5 to 9 bits
// - parity only for parity frame formats
module ucel_core
    import ucel_pkg::*;
#(
    parameter int BAUD_DIV = `UCEL_BAUD_DIV
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        rxd,
    input  wire logic        xck,
    output var  logic        txd,
    input  wire logic        standby,
    output var  logic        gclk_request,
    output var  logic        wake_request
);
    localparam int DW = $clog2(BAUD_DIV) + 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(BAUD_DIV - 1);
    localparam logic [DW-1:0] DIV_HALF = DW'(BAUD_DIV / 2);
    localparam logic [DW-1:0] DIV_QTR  = DW'(BAUD_DIV / 4);

    // pin synchronisers
    logic [1:0] rxd_meta_q, xck_meta_q;
    logic       rxd_s_q, xck_s_q, xck_old_q;
    always_ff @(posedge clock) begin
        rxd_meta_q <= {rxd_meta_q[0], rxd};
        xck_meta_q <= {xck_meta_q[0], xck};
        rxd_s_q    <= rxd_meta_q[1];
        xck_s_q    <= xck_meta_q[1];
        xck_old_q  <= xck_s_q;
    end
    wire xck_rise = xck_s_q & ~xck_old_q;
    wire xck_fall = ~xck_s_q & xck_old_q;

    // registers
    logic [31:0] ctrl_a_q, ctrl_b_q;
    logic [3:0]  irq_en_q;
    logic [7:0]  status_q;
    logic        sy_rst_q, sy_en_q, sy_cb_q;
    logic [3:0]  sync_cnt_q;
    logic        enabled_q, tx_live_q;
    logic [31:0] prdata_q;

    wire       soft_reset_request = ctrl_a_q[`UCEL_A_SOFT_RESET];
    wire [2:0] mode               = ctrl_a_q[`UCEL_A_MODE_HI:`UCEL_A_MODE_LO];
    wire       keep_running_in_sleep = ctrl_a_q[`UCEL_A_KEEP_RUN];
    wire [3:0] frame_format       = ctrl_a_q[`UCEL_A_FRAME_FORMAT_HI:`UCEL_A_FRAME_FORMAT_LO];
    wire [2:0] character_width    = ctrl_b_q[`UCEL_B_WIDTH_HI:`UCEL_B_WIDTH_LO];
    wire       stop_bit_count     = ctrl_b_q[`UCEL_B_STOP_BITS];
    wire       collision_check_enable = ctrl_b_q[`UCEL_B_COLL_EN];
    wire       start_bit_wake_enable  = ctrl_b_q[`UCEL_B_START_WAKE];
    wire       line_encoding_select   = ctrl_b_q[`UCEL_B_LINE_ENC];
    wire       parity_sense       = ctrl_b_q[`UCEL_B_PARITY_SENSE];
    wire       transmitter_on     = ctrl_b_q[`UCEL_B_TX_ON];
    wire       receiver_on        = ctrl_b_q[`UCEL_B_RX_ON];

    function automatic logic [3:0] width_of(input logic [2:0] code);
        unique case (code)
            `UCEL_CHW_9: width_of = 4'h9;
            `UCEL_CHW_5: width_of = 4'h5;
            `UCEL_CHW_6: width_of = 4'h6;
            `UCEL_CHW_7: width_of = 4'h7;
            default:     width_of = 4'h8;
        endcase
    endfunction : width_of

    wire [3:0] nbits      = width_of(character_width);
    wire       parity_on  = (frame_format == `UCEL_FRAME_FORMAT_PARITY) |
                            (frame_format == `UCEL_FRAME_FORMAT_AUTO_PAR);
    wire       int_clk    = (mode == `UCEL_MODE_INT_CLK);
    wire       ext_clk    = (mode == `UCEL_MODE_EXT_CLK);

    // bus decode
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire hit_a    = (paddr == `UCEL_OFF_CTRL_FIRST);
    wire hit_b    = (paddr == `UCEL_OFF_CTRL_SECOND);
    wire hit_ie   = (paddr == `UCEL_OFF_IRQ_EN);
    wire hit_st   = (paddr == `UCEL_OFF_STATUS);
    wire hit_sy   = (paddr == `UCEL_OFF_SYNC);
    wire hit_dat  = (paddr == `UCEL_OFF_DATA);
    wire mapped   = hit_a | hit_b | hit_ie | hit_st | hit_sy | hit_dat;

    ucel_buf_if #(.W(9)) tx_in ();
    ucel_buf_if #(.W(9)) tx_out ();

    wire wr_err   = access & pwrite & (soft_reset_request | ~mapped);
    wire data_stall = access & pwrite & hit_dat & ~tx_in.ready & ~wr_err;
    assign pready  = ~data_stall;
    assign pslverr = access & (wr_err | (~pwrite & ~mapped));
    wire wr_ok    = access & pwrite & ~wr_err & ~data_stall;
    wire wr_a     = wr_ok & hit_a;
    wire wr_b     = wr_ok & hit_b;
    wire rd_dat   = access & ~pwrite & hit_dat & ~soft_reset_request;
    wire start_rst = wr_a & pwdata[`UCEL_A_SOFT_RESET];
    wire sync_done = (sync_cnt_q == 4'h1);

    // transmit/receive engine state
    ucel_tx_state_type tx_st_q;
    ucel_rx_state_type rx_st_q;
    logic       tx_idle;
    logic       rx_idle;
    assign tx_idle = (tx_st_q == TX_IDLE);
    assign rx_idle = (rx_st_q == RX_IDLE);

    // standby gating
    wire busy_xfer  = ~tx_idle | ~rx_idle;
    wire clk_halted = standby & ~keep_running_in_sleep & ~busy_xfer;
    assign gclk_request = ~(standby & ~keep_running_in_sleep & int_clk & ~busy_xfer);
    wire rx_dropped = clk_halted & ext_clk;

    wire rx_live = enabled_q & receiver_on & ~sy_cb_q & ~rx_dropped;
    wire tx_off_req = ~transmitter_on | ~enabled_q;

    // control_first / control_second / sync flags
    always_ff @(posedge clock) begin
        if (!rst_b || start_rst) begin
            ctrl_a_q  <= `UCEL_RST_WORD;
            ctrl_b_q  <= `UCEL_RST_WORD;
            irq_en_q  <= '0;
            enabled_q <= 1'b0;
            sy_en_q   <= 1'b0;
            sy_cb_q   <= 1'b0;
            if (!rst_b) begin
                sy_rst_q   <= 1'b0;
                sync_cnt_q <= '0;
            end else begin
                ctrl_a_q[`UCEL_A_SOFT_RESET] <= 1'b1;
                sy_rst_q   <= 1'b1;
                sync_cnt_q <= `UCEL_SYNC_CYCLES;
            end
        end else begin
            if (sync_cnt_q != '0) sync_cnt_q <= sync_cnt_q - 4'h1;
            if (sync_done) begin
                ctrl_a_q[`UCEL_A_SOFT_RESET] <= 1'b0;
                sy_rst_q <= 1'b0;
                sy_en_q  <= 1'b0;
                sy_cb_q  <= 1'b0;
                enabled_q <= ctrl_a_q[`UCEL_A_ENABLE];
            end
            if (wr_a) begin
                ctrl_a_q[`UCEL_A_ENABLE] <= pwdata[`UCEL_A_ENABLE];
                if (!enabled_q && !ctrl_a_q[`UCEL_A_ENABLE]) begin
                    ctrl_a_q[31:2] <= pwdata[31:2];
                end
                if (pwdata[`UCEL_A_ENABLE] != ctrl_a_q[`UCEL_A_ENABLE]) begin
                    sy_en_q    <= 1'b1;
                    sync_cnt_q <= `UCEL_SYNC_CYCLES;
                end
            end
            if (wr_b) begin
                ctrl_b_q[`UCEL_B_RX_ON] <= pwdata[`UCEL_B_RX_ON];
                ctrl_b_q[`UCEL_B_TX_ON] <= pwdata[`UCEL_B_TX_ON];
                if (!enabled_q && !ctrl_a_q[`UCEL_A_ENABLE]) begin
                    ctrl_b_q[15:0] <= pwdata[15:0];
                end else if ((pwdata[`UCEL_B_RX_ON] & ~receiver_on) |
                             (pwdata[`UCEL_B_TX_ON] & ~transmitter_on)) begin
                    sy_cb_q    <= 1'b1;
                    sync_cnt_q <= `UCEL_SYNC_CYCLES;
                end
            end
            if (wr_ok && hit_ie) irq_en_q <= pwdata[3:0];
        end
    end

    // transmitter runs once synced, stops only when drained
    always_ff @(posedge clock) begin
        if (!rst_b || start_rst) begin
            tx_live_q <= 1'b0;
        end else if (enabled_q && transmitter_on && !sy_cb_q) begin
            tx_live_q <= 1'b1;
        end else if (tx_off_req && tx_idle && !tx_out.valid) begin
            tx_live_q <= 1'b0;
        end
    end

    // read data latched in setup phase
    wire [31:0] sync_word = {29'h0, sy_cb_q, sy_en_q, sy_rst_q};
    logic [8:0] rx_data_q;
    logic       rx_valid_q;
    wire [31:0] rd_mux =
        hit_a  ? ctrl_a_q :
        hit_b  ? ctrl_b_q :
        hit_ie ? {28'h0, irq_en_q} :
        hit_st ? {24'h0, status_q} :
        hit_sy ? sync_word :
        hit_dat ? {23'h0, rx_data_q} : `UCEL_RST_WORD;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata_q <= `UCEL_RST_WORD;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    // transmit buffer
    assign tx_in.valid = wr_ok & hit_dat;
    assign tx_in.data  = pwdata[8:0];
    ucel_pair_buf #(.W(9), .DEPTH(2)) u_txbuf (
        .clock (clock),
        .rst_b (rst_b),
        .flush (start_rst),
        .in_p  (tx_in),
        .out_p (tx_out)
    );

    // bit timing
    logic [DW-1:0] div_q, rx_div_q;
    always_ff @(posedge clock) begin
        if (!rst_b || div_q == DIV_LAST) div_q <= '0;
        else                             div_q <= div_q + 1'b1;
    end
    wire tx_tick = ~clk_halted & (int_clk ? (div_q == DIV_LAST) : xck_rise);

    // transmitter
    logic [8:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic       tx_par_q, tx_bit_q, coll_ev;
    assign tx_out.ready = tx_live_q & tx_idle & tx_tick;
    wire coll_seen = collision_check_enable & ~line_encoding_select & ~tx_idle &
                     tx_tick & (rxd_s_q != tx_bit_q);
    assign coll_ev = coll_seen;
    wire tx_done_ev = tx_tick & (tx_st_q == TX_STOP) & (tx_cnt_q == 4'h0);
    always_ff @(posedge clock) begin
        if (!rst_b || start_rst || coll_seen) begin
            tx_st_q  <= TX_IDLE;
            tx_bit_q <= 1'b1;
            tx_cnt_q <= '0;
            tx_sh_q  <= '0;
            tx_par_q <= 1'b0;
        end else if (tx_tick) begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    tx_bit_q <= 1'b1;
                    if (tx_out.valid && tx_live_q) begin
                        tx_sh_q  <= tx_out.data;
                        tx_par_q <= parity_sense;
                        tx_st_q  <= TX_START;
                        tx_bit_q <= 1'b0;
                    end
                end
                TX_START: begin
                    tx_bit_q <= tx_sh_q[0];
                    tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
                    tx_cnt_q <= nbits - 4'h1;
                    tx_st_q  <= TX_DATA;
                end
                TX_DATA: begin
                    if (tx_cnt_q == 4'h0) begin
                        tx_bit_q <= parity_on ? tx_par_q : 1'b1;
                        tx_st_q  <= parity_on ? TX_PARITY : TX_STOP;
                        tx_cnt_q <= {3'h0, stop_bit_count} ;
                    end else begin
                        tx_bit_q <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[8:1]};
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                    end
                end
                TX_PARITY: begin
                    tx_bit_q <= 1'b1;
                    tx_st_q  <= TX_STOP;
                end
                TX_STOP: begin
                    if (tx_cnt_q == 4'h0) tx_st_q <= TX_IDLE;
                    else                  tx_cnt_q <= tx_cnt_q - 4'h1;
                end
            endcase
        end
    end
    // pulse line: zero bits become a short low pulse
    wire irda_low = ~tx_bit_q & (div_q < DIV_QTR);
    always_ff @(posedge clock) begin
        if (!rst_b) txd <= 1'b1;
        else        txd <= line_encoding_select ? ~irda_low : tx_bit_q;
    end

    // receiver
    logic [8:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic       rx_par_q, rx_low_q, rx_old_q;
    wire rx_fall  = rx_old_q & ~rxd_s_q;
    wire rx_samp  = int_clk ? (rx_div_q == '0) : xck_fall;
    wire rx_bit   = line_encoding_select ? ~(rx_low_q | ~rxd_s_q) : rxd_s_q;
    wire rx_start_ev = rx_live & rx_idle & rx_fall;
    wire rx_end   = rx_samp & (rx_st_q == RX_STOP);
    wire rx_done_ev = rx_end & rx_bit;
    wire rx_flush = wr_b & ~pwdata[`UCEL_B_RX_ON];
    always_ff @(posedge clock) begin
        if (!rst_b) rx_old_q <= 1'b1;
        else        rx_old_q <= rxd_s_q;
    end
    always_ff @(posedge clock) begin
        if (!rst_b || !rx_live || start_rst) begin
            rx_st_q  <= RX_IDLE;
            rx_div_q <= '0;
            rx_cnt_q <= '0;
            rx_sh_q  <= '0;
            rx_par_q <= 1'b0;
            rx_low_q <= 1'b0;
        end else begin
            rx_div_q <= (rx_div_q == '0) ? DIV_LAST : rx_div_q - 1'b1;
            rx_low_q <= rx_samp ? 1'b0 : (rx_low_q | ~rxd_s_q);
            unique case (rx_st_q)
                RX_IDLE: if (rx_fall) begin
                    rx_div_q <= DIV_HALF;
                    rx_st_q  <= RX_START;
                    rx_par_q <= parity_sense;
                    rx_cnt_q <= nbits;
                end
                RX_START: if (rx_samp) rx_st_q <= rx_bit ? RX_IDLE : RX_DATA;
                RX_DATA: if (rx_samp) begin
                    rx_sh_q  <= {rx_bit, rx_sh_q[8:1]};
                    rx_par_q <= rx_par_q ^ rx_bit;
                    rx_cnt_q <= rx_cnt_q - 4'h1;
                    if (rx_cnt_q == 4'h1) rx_st_q <= parity_on ? RX_PARITY : RX_STOP;
                end
                RX_PARITY: if (rx_samp) begin
                    rx_par_q <= rx_par_q ^ rx_bit;
                    rx_st_q  <= RX_STOP;
                end
                RX_STOP: if (rx_samp) rx_st_q <= RX_IDLE;
            endcase
        end
    end
    wire [8:0] rx_word = rx_sh_q >> (4'h9 - nbits);
    wire parity_error_flag_ev = rx_end & parity_on & rx_par_q;
    wire frame_error_flag_ev = rx_end & ~rx_bit;
    wire ovf_ev  = rx_end & rx_valid_q & ~rd_dat;
    always_ff @(posedge clock) begin
        if (!rst_b || start_rst || rx_flush) begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= '0;
        end else if (rx_end) begin
            rx_valid_q <= 1'b1;
            rx_data_q  <= rx_word;
        end else if (rd_dat) begin
            rx_valid_q <= 1'b0;
        end
    end

    // status flags: write one clears, a new event wins
    wire [7:0] st_set = {2'b0, coll_ev, 2'b0, ovf_ev, frame_error_flag_ev, parity_error_flag_ev};
    wire [7:0] st_clr = (wr_ok & hit_st) ? pwdata[7:0] : 8'h00;
    always_ff @(posedge clock) begin
        if (!rst_b || start_rst) begin
            status_q <= '0;
        end else if (rx_flush) begin
            status_q <= (status_q & ~st_clr & 8'h20) | st_set;
        end else begin
            status_q <= (status_q & ~st_clr) | st_set;
        end
    end

    // wake sources
    wire rxs_w = start_bit_wake_enable & irq_en_q[`UCEL_IE_RXS] & rx_start_ev;
    wire rxc_w = irq_en_q[`UCEL_IE_RXC] & rx_done_ev;
    wire txc_w = irq_en_q[`UCEL_IE_TXC] & tx_done_ev;
    wire wake_d = standby & (
        (int_clk & ~keep_running_in_sleep & (rxs_w | txc_w)) |
        (int_clk &  keep_running_in_sleep & (rxs_w | rxc_w | txc_w)) |
        (ext_clk &  keep_running_in_sleep & (rxs_w | rxc_w)));
    always_ff @(posedge clock) begin
        if (!rst_b) wake_request <= 1'b0;
        else        wake_request <= wake_d;
    end
endmodule : ucel_core
`default_nettype wire

// ===== hw/ucel_pair_buf.sv
// Purpose: small word buffer with valid/ready on both sides
// Assumes: DEPTH of at least two, power of two
// Notes:   flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module ucel_pair_buf #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic flush,
    ucel_buf_if.dst   in_p,
    ucel_buf_if.src   out_p
);
    localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    wire           push = in_p.valid & in_p.ready;
    wire           pop  = out_p.valid & out_p.ready;

    assign in_p.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_p.valid = (cnt_q != '0);
    assign out_p.data  = mem_q[rd_q];

    always_ff @(posedge clock) begin
        if (!rst_b || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= AW'((wr_q + 1'b1) % DEPTH);
            if (pop)  rd_q <= AW'((rd_q + 1'b1) % DEPTH);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (push) mem_q[wr_q] <= in_p.data;
    end
endmodule : ucel_pair_buf
`default_nettype wire

// ===== hw/ucel_params.svh
// Purpose: constants for the serial control and enable logic
// Assumes: 32-bit register words, byte addresses
// Notes:   offsets are byte addresses
`ifndef UCEL_PARAMS_SVH
`define UCEL_PARAMS_SVH

`define UCEL_OFF_CTRL_FIRST  8'h00
`define UCEL_OFF_CTRL_SECOND 8'h04
`define UCEL_OFF_IRQ_EN      8'h14
`define UCEL_OFF_STATUS      8'h18
`define UCEL_OFF_SYNC        8'h1c
`define UCEL_OFF_DATA        8'h28

`define UCEL_RST_WORD        32'h0000_0000

// control_first fields
`define UCEL_A_SOFT_RESET    0
`define UCEL_A_ENABLE        1
`define UCEL_A_MODE_LO       2
`define UCEL_A_MODE_HI       4
`define UCEL_A_KEEP_RUN      7
`define UCEL_A_FRAME_FORMAT_LO       24
`define UCEL_A_FRAME_FORMAT_HI       27

// control_second fields
`define UCEL_B_WIDTH_LO      0
`define UCEL_B_WIDTH_HI      2
`define UCEL_B_STOP_BITS     6
`define UCEL_B_COLL_EN       8
`define UCEL_B_START_WAKE    9
`define UCEL_B_LINE_ENC      10
`define UCEL_B_PARITY_SENSE  13
`define UCEL_B_TX_ON         16
`define UCEL_B_RX_ON         17

// irq enable, status and sync-pending bits
`define UCEL_IE_TXC          1
`define UCEL_IE_RXC          2
`define UCEL_IE_RXS          3
`define UCEL_ST_PARITY       0
`define UCEL_ST_FRAME        1
`define UCEL_ST_OVERFLOW     2
`define UCEL_ST_COLLISION    5
`define UCEL_SY_SOFT_RESET   0
`define UCEL_SY_ENABLE       1
`define UCEL_SY_CTRL_SECOND  2

// codes
`define UCEL_MODE_EXT_CLK    3'h0
`define UCEL_MODE_INT_CLK    3'h1
`define UCEL_FRAME_FORMAT_PARITY     4'h1
`define UCEL_FRAME_FORMAT_AUTO_PAR   4'h5
`define UCEL_CHW_8           3'h0
`define UCEL_CHW_9           3'h1
`define UCEL_CHW_5           3'h5
`define UCEL_CHW_6           3'h6
`define UCEL_CHW_7           3'h7

// timing
`define UCEL_SYNC_CYCLES     4'h3
`define UCEL_BAUD_DIV        16

`endif

// ===== hw/ucel_pkg.sv
// Purpose: types of the serial control and enable logic
// Assumes: nothing beyond the parameter header
// Notes:   state enums carry no codes
package ucel_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ucel_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ucel_rx_state_type;
endpackage : ucel_pkg
